// ### design/sidsa_pkg.sv
// Constants, types and address helpers for the security id store host
package sidsa_pkg;
  // Device commands
  localparam logic [7:0]  CMD_READ_ID      = 8'h90;
  localparam logic [7:0]  CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0]  CMD_PROG_SETUP   = 8'hC0;
  localparam logic [15:0] LOCK_WORD_VALUE  = 16'hFFFD;
  localparam logic [7:0]  LOCK_BYTE_VALUE  = 8'hFD;
  // Lock word bits and device status bits
  localparam int          USER_LOCK_BIT    = 1;
  localparam int          FACTORY_LOCK_BIT = 0;
  localparam int          PROG_ERR_BIT     = 4;
  localparam int          LOCK_VIOL_BIT    = 1;
  // Store address map
  localparam logic [7:0]  WORD_BASE        = 8'h80;
  localparam logic [8:0]  BYTE_BASE        = 9'h100;
  localparam logic [4:0]  LOCK_INDEX       = 5'h00;
  // Bus timing
  localparam int          CLK_PERIOD_NS    = 50;
  localparam int          T_SETUP_NS       = 50;
  localparam int          T_STROBE_NS      = 150;
  localparam int          SETUP_CYC        = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          STROBE_CYC       = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Software register offsets
  localparam logic [3:0]  REG_CTRL         = 4'h0;
  localparam logic [3:0]  REG_CFG          = 4'h1;
  localparam logic [3:0]  REG_INDEX        = 4'h2;
  localparam logic [3:0]  REG_WDATA        = 4'h3;
  localparam logic [3:0]  REG_RDATA        = 4'h4;
  localparam logic [3:0]  REG_STATUS       = 4'h5;
  localparam logic [3:0]  REG_INT_STAT     = 4'h6;
  localparam logic [3:0]  REG_INT_MASK     = 4'h7;
  // Reset values
  localparam logic [15:0] RST_DATA         = 16'h0000;
  localparam logic [1:0]  RST_INT          = 2'h0;

  typedef enum logic [1:0] {OP_READ, OP_PROG, OP_LOCK, OP_EXIT} sidsa_op_t;

  // Word mode ignores A0; byte mode counts bytes sequentially
  function automatic logic [8:0] sidsa_store_addr(input logic byte_mode,
                                                  input logic [4:0] idx);
    logic [7:0] w;
    w = WORD_BASE + {3'h0, idx};
    if (byte_mode) begin
      sidsa_store_addr = BYTE_BASE + {4'h0, idx};
    end else begin
      sidsa_store_addr = {w, 1'b0};
    end
  endfunction
endpackage

// ### design/sidsa_bus_cycle.sv
// One asynchronous parallel bus cycle to the flash device
module sidsa_bus_cycle
  import sidsa_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        req,
  input  wire logic        wr,
  input  wire logic [8:0]  addr,
  input  wire logic [15:0] wdata,
  output logic             done,
  output logic [15:0]      rdata,
  output logic [8:0]       dev_addr,
  output logic             dev_ce_n,
  output logic             dev_oe_n,
  output logic             dev_we_n,
  output logic [15:0]      dev_dq_o,
  output logic             dev_dq_oe,
  input  wire logic [15:0] dev_dq_i
);
  typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_HOLD} sidsa_bc_t;

  sidsa_bc_t   st, next_st;
  logic [3:0]  cnt, next_cnt;
  logic        is_wr, next_is_wr;
  logic [8:0]  next_dev_addr;
  logic [15:0] next_dev_dq_o, next_rdata;
  logic        next_done;

  always_comb begin
    next_st       = st;
    next_cnt      = cnt;
    next_is_wr    = is_wr;
    next_dev_addr = dev_addr;
    next_dev_dq_o = dev_dq_o;
    next_rdata    = rdata;
    next_done     = 1'b0;
    case (st)
      BC_IDLE: begin
        if (req) begin
          next_st       = BC_SETUP;
          next_is_wr    = wr;
          next_dev_addr = addr;
          next_dev_dq_o = wdata;
          next_cnt      = 4'(SETUP_CYC);
        end
      end
      BC_SETUP: begin
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h1) begin
          next_st  = BC_STROBE;
          next_cnt = 4'(STROBE_CYC);
        end
      end
      BC_STROBE: begin
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h1) begin
          next_st = BC_HOLD;
          if (!is_wr) begin
            next_rdata = dev_dq_i;
          end
        end
      end
      default: begin
        next_st   = BC_IDLE;
        next_done = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st       <= BC_IDLE;
      cnt      <= 4'h0;
      is_wr    <= 1'b0;
      dev_addr <= 9'h000;
      dev_dq_o <= RST_DATA;
      rdata    <= RST_DATA;
      done     <= 1'b0;
    end else begin
      st       <= next_st;
      cnt      <= next_cnt;
      is_wr    <= next_is_wr;
      dev_addr <= next_dev_addr;
      dev_dq_o <= next_dev_dq_o;
      rdata    <= next_rdata;
      done     <= next_done;
    end
  end

  // Chip select spans the whole cycle; data driven from setup so it is stable at strobe rise
  assign dev_ce_n  = (st == BC_IDLE);
  assign dev_we_n  = !(st == BC_STROBE && is_wr);
  assign dev_oe_n  = !(st == BC_STROBE && !is_wr);
  assign dev_dq_oe = is_wr && (st != BC_IDLE);
endmodule

// ### design/sidsa_host.sv
// Host controller that reads, programs and locks the flash security id store
// Functional notes
// - Command 0x90 enters id read mode; store addresses then return contents.
// - Command 0xFF leaves id mode and returns to array read.
// - Program is setup 0xC0 then exactly one write with address and data.
// - Writing 0xFFFD to the lock word clears bit 1, locking user segment.
module sidsa_host
  import sidsa_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  output logic             irq,
  output logic [8:0]       dev_addr,
  output logic             dev_ce_n,
  output logic             dev_oe_n,
  output logic             dev_we_n,
  output logic             dev_byte_n,
  output logic [15:0]      dev_dq_o,
  output logic             dev_dq_oe,
  input  wire logic [15:0] dev_dq_i,
  input  wire logic        dev_ready
);
  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_ACCESS, ST_WAIT_RDY, ST_STAT_RD,
                            ST_EXIT} sidsa_st_t;

  sidsa_st_t   st, next_st;
  sidsa_op_t   op, next_op;
  logic        issued, next_issued;
  logic        byte_mode, next_byte_mode;
  logic [4:0]  index, next_index;
  logic [15:0] wdata, next_wdata;
  logic [15:0] rdata, next_rdata;
  logic        program_error_flag, next_program_error_flag;
  logic        lock_violation_flag, next_lock_violation_flag;
  logic [1:0]  int_stat, next_int_stat;
  logic [1:0]  int_mask, next_int_mask;
  logic [15:0] next_reg_rdata;
  logic        bus_req, bus_wr, bus_done;
  logic [8:0]  bus_addr;
  logic [15:0] bus_wdata, bus_rdata;
  logic        ev_done, ev_err, busy;

  assign busy       = (st != ST_IDLE);
  assign dev_byte_n = !byte_mode;

  // Bus request for the current step, issued once per state
  always_comb begin
    bus_req   = busy && !issued;
    bus_wr    = 1'b1;
    bus_addr  = sidsa_store_addr(byte_mode, index);
    bus_wdata = RST_DATA;
    case (st)
      ST_CMD: begin
        bus_wdata = (op == OP_READ) ? {8'h00, CMD_READ_ID} : {8'h00, CMD_PROG_SETUP};
      end
      ST_ACCESS: begin
        bus_wr = (op != OP_READ);
        if (op == OP_LOCK) begin
          bus_addr  = sidsa_store_addr(byte_mode, LOCK_INDEX);
          bus_wdata = byte_mode ? {8'h00, LOCK_BYTE_VALUE} : LOCK_WORD_VALUE;
        end else begin
          bus_wdata = byte_mode ? {8'h00, wdata[7:0]} : wdata;
        end
      end
      ST_STAT_RD: begin
        bus_wr = 1'b0;
      end
      ST_EXIT: begin
        bus_wdata = {8'h00, CMD_READ_ARRAY};
      end
      default: begin
        bus_req = 1'b0;
      end
    endcase
  end

  // Sequencer
  always_comb begin
    next_st                  = st;
    next_op                  = op;
    next_issued              = issued;
    next_rdata               = rdata;
    next_program_error_flag  = program_error_flag;
    next_lock_violation_flag = lock_violation_flag;
    ev_done                  = 1'b0;
    ev_err                   = 1'b0;
    if (bus_req) begin
      next_issued = 1'b1;
    end
    case (st)
      ST_IDLE: begin
        // Start while busy is ignored
        if (reg_wr && reg_addr == REG_CTRL && reg_wdata[0]) begin
          next_op     = sidsa_op_t'(reg_wdata[2:1]);
          next_st     = (next_op == OP_EXIT) ? ST_EXIT : ST_CMD;
          next_issued = 1'b0;
          if (next_op != OP_READ && next_op != OP_EXIT) begin
            next_program_error_flag  = 1'b0;
            next_lock_violation_flag = 1'b0;
          end
        end
      end
      ST_CMD: begin
        if (bus_done) begin
          next_st     = ST_ACCESS;
          next_issued = 1'b0;
        end
      end
      ST_ACCESS: begin
        if (bus_done) begin
          next_st     = (op == OP_READ) ? ST_EXIT : ST_WAIT_RDY;
          next_issued = 1'b0;
          if (op == OP_READ) begin
            next_rdata = byte_mode ? {8'h00, bus_rdata[7:0]} : bus_rdata;
          end
        end
      end
      ST_WAIT_RDY: begin
        // Device busy for an unknown time; no timeout, software sees busy
        if (dev_ready) begin
          next_st = ST_STAT_RD;
        end
      end
      ST_STAT_RD: begin
        if (bus_done) begin
          next_program_error_flag  = bus_rdata[PROG_ERR_BIT];
          next_lock_violation_flag = bus_rdata[LOCK_VIOL_BIT];
          ev_err                   = bus_rdata[PROG_ERR_BIT] || bus_rdata[LOCK_VIOL_BIT];
          next_st                  = ST_EXIT;
          next_issued              = 1'b0;
        end
      end
      default: begin
        if (bus_done) begin
          next_st = ST_IDLE;
          ev_done = 1'b1;
        end
      end
    endcase
  end

  // Software registers; an event in the clearing read still lands
  always_comb begin
    next_byte_mode = byte_mode;
    next_index     = index;
    next_wdata     = wdata;
    next_int_mask  = int_mask;
    next_int_stat  = int_stat;
    next_reg_rdata = RST_DATA;
    if (reg_wr) begin
      if (reg_addr == REG_CFG && !busy) begin
        next_byte_mode = reg_wdata[0];
      end else if (reg_addr == REG_INDEX && !busy) begin
        next_index = reg_wdata[4:0];
      end else if (reg_addr == REG_WDATA && !busy) begin
        next_wdata = reg_wdata;
      end else if (reg_addr == REG_INT_MASK) begin
        next_int_mask = reg_wdata[1:0];
      end
    end
    if (reg_rd) begin
      if (reg_addr == REG_CFG) begin
        next_reg_rdata = {15'h0000, byte_mode};
      end else if (reg_addr == REG_INDEX) begin
        next_reg_rdata = {11'h000, index};
      end else if (reg_addr == REG_WDATA) begin
        next_reg_rdata = wdata;
      end else if (reg_addr == REG_RDATA) begin
        next_reg_rdata = rdata;
      end else if (reg_addr == REG_STATUS) begin
        next_reg_rdata = {13'h0000, lock_violation_flag, program_error_flag, busy};
      end else if (reg_addr == REG_INT_STAT) begin
        next_reg_rdata = {14'h0000, int_stat};
        next_int_stat  = RST_INT;
      end else if (reg_addr == REG_INT_MASK) begin
        next_reg_rdata = {14'h0000, int_mask};
      end
    end
    next_int_stat = next_int_stat | {ev_err, ev_done};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st                  <= ST_IDLE;
      op                  <= OP_READ;
      issued              <= 1'b0;
      byte_mode           <= 1'b0;
      index               <= 5'h00;
      wdata               <= RST_DATA;
      rdata               <= RST_DATA;
      program_error_flag  <= 1'b0;
      lock_violation_flag <= 1'b0;
      int_stat            <= RST_INT;
      int_mask            <= RST_INT;
      reg_rdata           <= RST_DATA;
    end else begin
      st                  <= next_st;
      op                  <= next_op;
      issued              <= next_issued;
      byte_mode           <= next_byte_mode;
      index               <= next_index;
      wdata               <= next_wdata;
      rdata               <= next_rdata;
      program_error_flag  <= next_program_error_flag;
      lock_violation_flag <= next_lock_violation_flag;
      int_stat            <= next_int_stat;
      int_mask            <= next_int_mask;
      reg_rdata           <= next_reg_rdata;
    end
  end

  assign irq = |(int_stat & int_mask);

  sidsa_bus_cycle u_bus (
    .clk       (clk),
    .rst       (rst),
    .req       (bus_req),
    .wr        (bus_wr),
    .addr      (bus_addr),
    .wdata     (bus_wdata),
    .done      (bus_done),
    .rdata     (bus_rdata),
    .dev_addr  (dev_addr),
    .dev_ce_n  (dev_ce_n),
    .dev_oe_n  (dev_oe_n),
    .dev_we_n  (dev_we_n),
    .dev_dq_o  (dev_dq_o),
    .dev_dq_oe (dev_dq_oe),
    .dev_dq_i  (dev_dq_i)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_setup_done;
    bus_done && st == ST_CMD && op != OP_READ;
  endsequence

  property p_id_cmd;
    bus_req && st == ST_CMD && op == OP_READ |-> bus_wr && bus_wdata == 16'h0090;
  endproperty
  a_id_cmd: assert property (p_id_cmd) else $error("id read command wrong");

  property p_exit_cmd;
    bus_req && st == ST_EXIT |-> bus_wr && bus_wdata == 16'h00FF ##6 bus_done;
  endproperty
  a_exit_cmd: assert property (p_exit_cmd) else $error("exit command wrong");

  property p_one_write;
    s_setup_done |=> st == ST_ACCESS && bus_req && bus_wr ##1 !bus_req [*4] ##[1:4] bus_done;
  endproperty
  a_one_write: assert property (p_one_write) else $error("program write not single");

  property p_lock_value;
    bus_req && st == ST_ACCESS && op == OP_LOCK
      |-> bus_wdata == (byte_mode ? 16'h00FD : 16'hFFFD) && bus_addr == 9'h100;
  endproperty
  a_lock_value: assert property (p_lock_value) else $error("lock word value wrong");

  property p_poll;
    st == ST_WAIT_RDY && !dev_ready |=> st == ST_WAIT_RDY;
  endproperty
  a_poll: assert property (p_poll) else $error("left poll before ready");

  property p_flags;
    bus_done && st == ST_STAT_RD |=> program_error_flag == $past(bus_rdata[4])
      && lock_violation_flag == $past(bus_rdata[1]) && st == ST_EXIT;
  endproperty
  a_flags: assert property (p_flags) else $error("error flags not captured");
endmodule

// ### sim/sidsa_flash_model.sv
// Behavioural flash device holding the security id store
module sidsa_flash_model #(
  parameter logic [63:0] FACTORY_ID = 64'h0123_4567_89AB_CDEF // Arbitrary value
) (
  input  wire logic        clk,
  input  wire logic [7:0]  lat,
  input  wire logic [8:0]  dev_addr,
  input  wire logic        dev_ce_n,
  input  wire logic        dev_oe_n,
  input  wire logic        dev_we_n,
  input  wire logic        dev_byte_n,
  input  wire logic [15:0] dev_dq_o,
  input  wire logic        dev_dq_oe,
  output logic [15:0]      dev_dq_i,
  output logic             dev_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [0:17];
  logic [1:0]  mode;
  logic [7:0]  sr;
  logic [7:0]  busy;
  logic        we_q;
  int          wb;
  int          rb;
  logic [15:0] rv;

  // Byte index into the store, -1 outside it
  function automatic int bidx(input logic [8:0] a, input logic bm);
    if (bm) return (a >= 9'h100 && a <= 9'h111) ? int'(a - 9'h100) : -1;
    return (a[8:1] >= 8'h80 && a[8:1] <= 8'h88) ? 2 * int'(a[8:1] - 8'h80) : -1;
  endfunction

  initial begin
    for (int i = 0; i < 18; i++) mem[i] = 8'hFF;
    for (int i = 0; i < 8; i++) mem[2 + i] = FACTORY_ID[8 * i +: 8];
    mem[0] = 8'hFE;
    mode = 2'd0;
    sr = 8'h80;
    busy = 8'h00;
    we_q = 1'b1;
    dev_dq_i = 16'h0000;
  end

  assign dev_ready = (busy == 8'h00);

  // Commands and data are taken on the rising edge of the write strobe
  always @(posedge clk) begin
    we_q <= dev_we_n;
    if (busy != 8'h00) busy <= busy - 8'h01;
    // Only data the host actually drives is taken
    if (dev_we_n && !we_q && !dev_ce_n && dev_dq_oe) begin
      wb = bidx(dev_addr, !dev_byte_n);
      if (mode == 2'd3) begin
        mode <= 2'd2;
        busy <= lat;
        sr = 8'h80;
        if (wb < 0) sr = 8'h90;
        else if ((wb >= 2 && wb < 10 && !mem[0][0]) || (wb >= 10 && !mem[0][1])) begin
          sr = 8'h92;
        end else begin
          mem[wb] <= mem[wb] & dev_dq_o[7:0];
          if (dev_byte_n) mem[wb + 1] <= mem[wb + 1] & dev_dq_o[15:8];
        end
      end else begin
        case (dev_dq_o[7:0])
          8'h90: mode <= 2'd1;
          8'hFF: mode <= 2'd0;
          8'hC0: mode <= 2'd3;
          default: ;
        endcase
      end
    end
  end

  // No pull on the data bus, so a released bus shows a moving value
  always @(posedge clk) begin
    if (!dev_ce_n && !dev_oe_n) begin
      rb = bidx(dev_addr, !dev_byte_n);
      case (mode)
        2'd1: rv = (rb < 0) ? 16'h0000 : {dev_byte_n ? mem[rb + 1] : ~mem[rb], mem[rb]};
        2'd2: rv = {8'h00, dev_ready, sr[6:0]};
        default: rv = 16'h5A5A;
      endcase
      dev_dq_i <= rv;
    end else dev_dq_i <= ~dev_dq_i;
  end
endmodule

// ### sim/testbench.sv
// Self-checking bench for the security id store host
module testbench
  import sidsa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, reg_wr, reg_rd, irq, dev_ce_n, dev_oe_n, dev_we_n;
  logic        dev_byte_n, dev_dq_oe, dev_ready, rd_seen, we_d;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, dev_dq_o, dev_dq_i, last_rd, cmd_hist, fl, d;
  logic [8:0]  dev_addr;
  logic [7:0]  lat;
  logic [7:0]  exp_mem [0:17];
  logic [31:0] rnd, e;
  logic [31:0] expq [$];
  int          n_mismatch, n_checks;

  sidsa_host i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .dev_addr(dev_addr), .dev_ce_n(dev_ce_n), .dev_oe_n(dev_oe_n), .dev_we_n(dev_we_n),
    .dev_byte_n(dev_byte_n), .dev_dq_o(dev_dq_o), .dev_dq_oe(dev_dq_oe),
    .dev_dq_i(dev_dq_i), .dev_ready(dev_ready));
  sidsa_flash_model i_flash (.clk(clk), .lat(lat), .dev_addr(dev_addr),
    .dev_ce_n(dev_ce_n), .dev_oe_n(dev_oe_n), .dev_we_n(dev_we_n),
    .dev_byte_n(dev_byte_n), .dev_dq_o(dev_dq_o), .dev_dq_oe(dev_dq_oe), .dev_dq_i(dev_dq_i),
    .dev_ready(dev_ready));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Strobes stay up between back-to-back calls; idle drops them
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] x, input logic [15:0] m);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    expq.push_back({x, m});
    @(posedge clk);
  endtask
  task automatic idle();
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  // Result watcher: one note per read, zero mask means not compared
  always @(posedge clk) begin
    if (rd_seen) begin
      last_rd = reg_rdata;
      e = expq.pop_front();
      if (e[15:0] != 16'h0) check("rdata", reg_rdata & e[15:0], e[31:16] & e[15:0]);
    end
    rd_seen <= reg_rd;
    we_d <= dev_we_n;
    if (dev_we_n && !we_d && !dev_ce_n) cmd_hist <= {cmd_hist[7:0], dev_dq_o[7:0]};
  end

  task automatic op(input logic [1:0] o, input int ix, input logic [15:0] v);
    rnd = lfsr_next(rnd);
    lat <= {2'b00, rnd[21:16]};
    wr(REG_INDEX, 16'(ix));
    wr(REG_WDATA, v);
    wr(REG_CTRL, {13'h0, o, 1'b1});
    for (int i = 0; i < 400; i++) begin
      rd(REG_STATUS, 16'h0, 16'h0);
      idle();
      @(posedge clk);
      if (last_rd[0] === 1'b0) return;
    end
    n_mismatch++;
  endtask

  // Expected flags of a program, mirror updated when it lands
  function automatic logic [15:0] prog_flags(input int bm, input int ix, input logic [15:0] v);
    int b;
    b = bm ? ix : 2 * ix;
    if (b > 17) return 16'h0002;
    if ((b >= 2 && b < 10 && !exp_mem[0][0]) || (b >= 10 && !exp_mem[0][1])) return 16'h0006;
    exp_mem[b] &= v[7:0];
    if (bm == 0) exp_mem[b + 1] &= v[15:8];
    return 16'h0000;
  endfunction
  function automatic logic [15:0] exp_val(input int bm, input int ix);
    return bm ? {8'h00, exp_mem[ix]} : {exp_mem[2 * ix + 1], exp_mem[2 * ix]};
  endfunction

  task automatic prog_read(input int bm, input int ix, input logic [15:0] v);
    fl = prog_flags(bm, ix, v);
    op(OP_PROG, ix, v);
    rd(REG_STATUS, fl, 16'hFFFF);
    idle();
    op(OP_READ, ix, 16'h0);
    if (ix < (bm ? 18 : 9)) rd(REG_RDATA, exp_val(bm, ix), bm ? 16'h00FF : 16'hFFFF);
    idle();
  endtask

  initial begin
    for (int i = 0; i < 18; i++) exp_mem[i] = 8'hFF;
    for (int i = 0; i < 8; i++) exp_mem[2 + i] = i_flash.FACTORY_ID[8 * i +: 8];
    exp_mem[0] = 8'hFE;
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata, lat, rd_seen, we_d} = {3'b100, 30'h1};
    rnd = 32'h9955DE2E;
    cmd_hist = 16'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("irq", {15'h0, irq}, 16'h0);
    rd(REG_STATUS, 16'h0, 16'hFFFF);
    rd(4'h9, 16'h0, 16'hFFFF);
    rd(REG_INT_STAT, 16'h0, 16'hFFFF);
    wr(REG_INT_MASK, 16'h3);
    rd(REG_INT_MASK, 16'h3, 16'hFFFF);
    rd(REG_CFG, 16'h0, 16'hFFFF);
    idle();
    $display("reset test done");
    for (int bm = 0; bm < 2; bm++) begin
      wr(REG_CFG, 16'(bm));
      idle();
      check("byte_n", {15'h0, dev_byte_n}, 16'(1 - bm));
      for (int ix = 0; ix < (bm ? 18 : 9); ix++) begin
        op(OP_READ, ix, 16'h0);
        rd(REG_RDATA, exp_val(bm, ix), bm ? 16'h00FF : 16'hFFFF);
        idle();
        check("cmds", cmd_hist, 16'h90FF);
      end
      rnd = lfsr_next(rnd);
      d = rnd[15:0];
      prog_read(bm, bm ? 12 : 5, d);
      prog_read(bm, bm ? 3 : 1, d);
      prog_read(bm, bm ? 18 : 9, d);
      check("irq", {15'h0, irq}, 16'h1);
      wr(REG_INT_MASK, 16'h0);
      idle();
      check("irq", {15'h0, irq}, 16'h0);
      wr(REG_INT_MASK, 16'h3);
      rd(REG_INT_STAT, 16'h3, 16'hFFFF);
      idle();
      check("irq", {15'h0, irq}, 16'h0);
      $display("mode %0d test done", bm);
    end
    wr(REG_CFG, 16'h0);
    fl = prog_flags(0, 0, LOCK_WORD_VALUE);
    op(OP_LOCK, 0, LOCK_WORD_VALUE);
    rd(REG_STATUS, fl, 16'hFFFF);
    rd(REG_WDATA, LOCK_WORD_VALUE, 16'hFFFF);
    rd(REG_INDEX, 16'h0, 16'hFFFF);
    idle();
    prog_read(0, 6, 16'h1234);
    prog_read(0, 0, 16'hFFFF);
    // Byte-wide lock hits the low lock byte; upper read bits must stay zero
    wr(REG_CFG, 16'h1);
    fl = prog_flags(1, 0, LOCK_WORD_VALUE);
    op(OP_LOCK, 0, LOCK_WORD_VALUE);
    rd(REG_STATUS, fl, 16'hFFFF);
    idle();
    op(OP_READ, 0, 16'h0);
    rd(REG_RDATA, exp_val(1, 0), 16'hFFFF);
    idle();
    op(OP_EXIT, 0, 16'h0);
    check("cmds", cmd_hist[7:0], 16'h00FF);
    $display("lock test done");
    complete_run();
  end

  initial begin
    #3000000;
    n_mismatch++;
    complete_run();
  end
endmodule
